// >>> verif/plsld_host.sv
// Host model: power-save pins, serial word, oscillator and divided VCO lines
`timescale 1ns/100ps
module plsld_host import plsld_pkg::*; (
  input wire logic clock,
  output logic if_power_save_n,
  output logic rf_power_save_n,
  output logic ref_osc_input,
  output logic if_divided_vco_freq,
  output logic rf_divided_vco_freq,
  output logic serial_clock,
  output logic serial_data,
  output logic load_strobe
);
  // ----
  // Free-running lines; equal half periods keep them in phase
  // ----
  int cnt = 0;
  int osc_half = 4;
  int if_vco_half = 4;
  int rf_vco_half = 4;
  initial begin
    if_power_save_n = 1'b0;
    rf_power_save_n = 1'b0;
    ref_osc_input = 1'b0;
    if_divided_vco_freq = 1'b0;
    rf_divided_vco_freq = 1'b0;
    serial_clock = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end
  always @(posedge clock) begin
    cnt <= cnt + 1;
    ref_osc_input <= 1'((cnt / osc_half) % 2);
    if_divided_vco_freq <= 1'((cnt / if_vco_half) % 2);
    rf_divided_vco_freq <= 1'((cnt / rf_vco_half) % 2);
  end
  task automatic set_ps(input logic ifv, input logic rfv);
    while (cnt < 100) @(posedge clock);
    @(posedge clock);
    if_power_save_n <= ifv;
    rf_power_save_n <= rfv;
  endtask
  // Data held well past each rise since the pin path is synchronised
  task automatic send_word(input logic [WORD_BITS-1:0] w);
    for (int i = WORD_BITS - 1; i >= 0; i--) begin
      @(posedge clock);
      serial_data <= w[i];
      repeat (3) @(posedge clock);
      serial_clock <= 1'b1;
      repeat (6) @(posedge clock);
      serial_clock <= 1'b0;
      repeat (2) @(posedge clock);
    end
    serial_data <= ~w[0];
  endtask
  task automatic load();
    repeat (6) @(posedge clock);
    load_strobe <= 1'b1;
    repeat (6) @(posedge clock);
    load_strobe <= 1'b0;
  endtask
endmodule

// >>> verif/plsld_top_properties.sv
// Checker: pin-level relations of the synthesizer control block
`timescale 1ns/100ps
module plsld_checker (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic if_power_save_n,
  input wire logic rf_power_save_n,
  input wire logic load_strobe,
  input wire logic if_pd_oe,
  input wire logic rf_pd_oe,
  input wire logic if_modulus_ctrl,
  input wire logic if_presc_sel,
  input wire logic rf_presc_sel,
  input wire logic lock_detect_out,
  input wire logic osc_buffer_on,
  input wire logic if_counters_on,
  input wire logic rf_counters_on
);
  // ----
  // Cycles since load strobe was last high
  // ----
  logic [3:0] quiet;
  logic [3:0] next_quiet;
  always_comb begin
    next_quiet = quiet;
    if (load_strobe) next_quiet = 4'h0;
    else if (quiet != 4'hf) next_quiet = quiet + 4'h1;
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) quiet <= 4'h0;
    else quiet <= next_quiet;
  end
  // ----
  // Properties; pins must settle 8 cycles to cover the synchroniser
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_if_off; !if_power_save_n [*8]; endsequence
  sequence s_rf_off; !rf_power_save_n [*8]; endsequence
  sequence s_if_on; if_power_save_n [*8]; endsequence
  sequence s_all_off; (!if_power_save_n && !rf_power_save_n) [*8]; endsequence
  property p_if_cnt; s_if_off |-> !if_counters_on; endproperty
  a_if_cnt: assert property (p_if_cnt) else $error("IF counters run asleep");
  property p_rf_cnt; rf_power_save_n [*8] |-> rf_counters_on; endproperty
  a_rf_cnt: assert property (p_rf_cnt) else $error("RF counters idle awake");
  property p_osc_off; s_all_off |-> !osc_buffer_on; endproperty
  a_osc_off: assert property (p_osc_off) else $error("Osc buffer on asleep");
  property p_osc_on; s_if_on |-> osc_buffer_on; endproperty
  a_osc_on: assert property (p_osc_on) else $error("Osc buffer off awake");
  property p_if_float; s_if_off |-> !if_pd_oe; endproperty
  a_if_float: assert property (p_if_float) else $error("IF detector driven asleep");
  property p_rf_float; s_rf_off |-> !rf_pd_oe; endproperty
  a_rf_float: assert property (p_rf_float) else $error("RF detector driven asleep");
  property p_lock_sleep; s_all_off |-> lock_detect_out; endproperty
  a_lock_sleep: assert property (p_lock_sleep) else $error("Lock low asleep");
  property p_if_mod; s_if_off |-> !if_modulus_ctrl; endproperty
  a_if_mod: assert property (p_if_mod) else $error("IF modulus active asleep");
  property p_cfg_hold; quiet > 4'h9 |-> $stable(if_presc_sel) && $stable(rf_presc_sel);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("Config changed without load");
endmodule
bind plsld_top plsld_checker plsld_checker_inst (.clock(clock), .reset_n(reset_n),
  .if_power_save_n(if_power_save_n), .rf_power_save_n(rf_power_save_n),
  .load_strobe(load_strobe), .if_pd_oe(if_pd_oe), .rf_pd_oe(rf_pd_oe),
  .if_modulus_ctrl(if_modulus_ctrl), .if_presc_sel(if_presc_sel),
  .rf_presc_sel(rf_presc_sel), .lock_detect_out(lock_detect_out),
  .osc_buffer_on(osc_buffer_on), .if_counters_on(if_counters_on),
  .rf_counters_on(rf_counters_on));

// >>> verif/plsld_top_tb.sv
// Testbench: serial load, power save and lock output of the synthesizer control
`timescale 1ns/100ps
module plsld_top_tb import plsld_pkg::*;;
  logic clock, reset_n;
  logic if_power_save_n, rf_power_save_n, ref_osc_input, if_divided_vco_freq;
  logic rf_divided_vco_freq, serial_clock, serial_data, load_strobe;
  logic if_pd_oe, rf_pd_oe, rf_pd_out, if_presc_sel, rf_presc_sel, lock_detect_out;
  logic osc_buffer_on, if_counters_on, rf_counters_on;
  plsld_pump_type if_pump;
  int num_errors = 0;
  int n_compared = 0;
  plsld_host plsld_host_inst (.clock(clock), .if_power_save_n(if_power_save_n),
    .rf_power_save_n(rf_power_save_n), .ref_osc_input(ref_osc_input),
    .if_divided_vco_freq(if_divided_vco_freq), .rf_divided_vco_freq(rf_divided_vco_freq),
    .serial_clock(serial_clock), .serial_data(serial_data), .load_strobe(load_strobe));
  plsld_top plsld_top_inst (.clock(clock), .reset_n(reset_n),
    .if_power_save_n(if_power_save_n), .rf_power_save_n(rf_power_save_n),
    .ref_osc_input(ref_osc_input), .if_divided_vco_freq(if_divided_vco_freq),
    .rf_divided_vco_freq(rf_divided_vco_freq), .serial_clock(serial_clock),
    .serial_data(serial_data), .load_strobe(load_strobe), .if_pd_out(),
    .if_pd_oe(if_pd_oe), .rf_pd_out(rf_pd_out), .rf_pd_oe(rf_pd_oe), .if_pump(if_pump),
    .rf_pump(), .if_modulus_ctrl(), .rf_modulus_ctrl(), .if_presc_sel(if_presc_sel),
    .rf_presc_sel(rf_presc_sel), .lock_detect_out(lock_detect_out),
    .osc_buffer_on(osc_buffer_on), .if_counters_on(if_counters_on),
    .rf_counters_on(rf_counters_on));
  // ----
  // Helpers; main ratio and reference ratio kept at 5 so the loops can lock
  // ----
  function automatic logic [22:0] main_word(logic [1:0] d, logic sw, logic [6:0] a, logic fc);
    return {11'h005, a, fc, sw, 1'b0, d};
  endfunction
  function automatic logic [22:0] ref_word(logic [1:0] d, logic [4:0] x);
    return {x, 2'h0, 14'h0005, d};
  endfunction
  function automatic logic exp_osc(logic a, logic b);
    return a | b;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Mode 0 waits on the lock pin, 1 on both IF pump lines high, 2 on the RF detector enable
  task automatic wait_for(input logic [1:0] what, input logic v, input int bound);
    int i;
    for (i = 0; i < bound; i++) begin
      @(negedge clock);
      if (what == 2'h1 ? (if_pump === 2'h3) : what == 2'h2 ? (rf_pd_oe === v) :
          (lock_detect_out === v)) break;
    end
    if (i == bound) begin
      num_errors++;
      $display("ERROR at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    int s;
    int i;
    logic [1:0] d;
    logic sw, fc, fc_rf, ifv, rfv, exp_if, exp_rf;
    reset_n = 1'b0;
    fc_rf = 1'b0;
    exp_if = 1'b0;
    exp_rf = 1'b0;
    s = $urandom(32'h062611e8);
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (10) @(negedge clock);
    check(if_presc_sel, 1'b0);
    check(osc_buffer_on, 1'b0);
    check(lock_detect_out, 1'b1);
    // Words shifted while both sections sleep; every destination first
    for (i = 0; i < 8; i++) begin
      d = (i < 4) ? 2'(i) : 2'($urandom);
      sw = (i < 4) ? 1'b1 : 1'($urandom);
      fc = 1'($urandom);
      plsld_host_inst.send_word(d[1] ? main_word(d, sw, 7'($urandom), fc)
                                     : ref_word(d, 5'($urandom)));
      repeat (8) @(negedge clock);
      check({if_presc_sel, rf_presc_sel}, {exp_if, exp_rf});
      plsld_host_inst.load();
      repeat (8) @(negedge clock);
      if (d == DEST_IF_MAIN) exp_if = sw;
      if (d == DEST_RF_MAIN) exp_rf = sw;
      if (d == DEST_RF_MAIN) fc_rf = fc;
      check({if_presc_sel, rf_presc_sel}, {exp_if, exp_rf});
    end
    for (i = 0; i < 8; i++) begin
      {rfv, ifv} = (i < 4) ? 2'(i) : 2'($urandom);
      plsld_host_inst.set_ps(ifv, rfv);
      repeat (10) @(negedge clock);
      check({if_counters_on, rf_counters_on}, {ifv, rfv});
      check(osc_buffer_on, exp_osc(ifv, rfv));
    end
    plsld_host_inst.set_ps(1'b0, 1'b0);
    repeat (10) @(negedge clock);
    check(lock_detect_out, 1'b1);
    // IF wakes alone; its first comparison must not yet report lock
    plsld_host_inst.set_ps(1'b1, 1'b0);
    wait_for(2'h1, 1'b0, 2000);
    check(if_pump, 2'h3);
    check(lock_detect_out, 1'b0);
    wait_for(2'h0, 1'b1, 5000);
    check(lock_detect_out, 1'b1);
    // RF joins in phase and locks; a slower VCO then pushes it past the unlock width
    plsld_host_inst.set_ps(1'b1, 1'b1);
    wait_for(2'h0, 1'b0, 20);
    check(lock_detect_out, 1'b0);
    wait_for(2'h0, 1'b1, 5000);
    check(lock_detect_out, 1'b1);
    plsld_host_inst.rf_vco_half = 6;
    wait_for(2'h0, 1'b0, 3000);
    check(lock_detect_out, 1'b0);
    // Once the beat settles the reference side always leads
    repeat (200) @(negedge clock);
    wait_for(2'h2, 1'b1, 200);
    check(rf_pd_oe, 1'b1);
    check(rf_pd_out, fc_rf);
    plsld_host_inst.set_ps(1'b1, 1'b0);
    wait_for(2'h0, 1'b1, 20);
    check(lock_detect_out, 1'b1);
    end_of_test();
  end
endmodule

// >>> verilog/plsld_pkg.sv
// Package: constants and types for the dual synthesizer control block
// Summary of operation
// - Low power-save pin powers section down
// - Wake-up limits phase detector error output
// - Serial shifting continues during power saving
// - Powered-down section logic stops entirely
// - Powered-down section: detector high-Z, reports locked
// - Counters follow own pin; oscillator needs either
// - Shift one bit per serial clock rise
// - Lock high only if both locked/saving (with lds set the pin carries the selected test signal instead)
// - Error at upper threshold forces unlock
// - Three small-error comparisons needed for lock
// - Thresholds counted in reference oscillator periods
// - Correction pulses even at zero error
// - Two trailing control bits pick destination
package plsld_pkg;

  // ----------------------------------------
  // Pin synchroniser slots
  // ----------------------------------------
  localparam int PIN_COUNT = 8;
  localparam int PIN_PS_IF = 0;
  localparam int PIN_PS_RF = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_SDATA = 3;
  localparam int PIN_LOAD = 4;
  localparam int PIN_OSC = 5;
  localparam int PIN_VCO_IF = 6;
  localparam int PIN_VCO_RF = 7;

  // ----------------------------------------
  // Serial word layout
  // ----------------------------------------
  localparam int WORD_BITS = 23;
  localparam int POS_SEL_A = 0;
  localparam int POS_SEL_B = 1;
  localparam int POS_REF_LO = 2;
  localparam int POS_TEST_LO = 16;
  localparam int POS_LDS = 2;
  localparam int POS_SW = 3;
  localparam int POS_FC = 4;
  localparam int POS_SWAL_LO = 5;
  localparam int POS_MAIN_LO = 12;
  localparam logic [1:0] DEST_IF_REF = 2'h0;
  localparam logic [1:0] DEST_RF_REF = 2'h1;
  localparam logic [1:0] DEST_IF_MAIN = 2'h2;
  localparam logic [1:0] DEST_RF_MAIN = 2'h3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [13:0] RESET_REF = 14'h0005;
  localparam logic [10:0] RESET_MAIN = 11'h005;
  localparam logic [6:0] RESET_SWAL = 7'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DZ_PULSE_NS = 20;
  localparam int DZ_PULSE_CYC = (DZ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] UNLOCK_OSC = 3'h4;
  localparam logic [2:0] LOCK_OSC = 3'h3;
  localparam logic [1:0] LOCK_RUNS = 2'h3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [13:0] ref_ratio;
    logic [10:0] main_ratio;
    logic [6:0] swallow;
    logic presc_sel;
    logic phase_pol;
  } plsld_cfg_type;

  typedef struct packed {
    logic up;
    logic dn;
  } plsld_pump_type;

endpackage

// >>> verilog/plsld_section.sv
// One synthesizer section: dividers, phase detector, lock qualifier
`timescale 1ns/100ps
module plsld_section import plsld_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic osc_tick,
  input wire logic vco_tick,
  input wire plsld_cfg_type cfg,
  output plsld_pump_type pump,
  output logic reference_compare_freq,
  output logic divided_vco_freq,
  output logic modulus_ctrl,
  output logic drive_ok,
  output logic locked
);

  logic en_q, next_en_q;
  logic [13:0] ref_cnt, next_ref_cnt;
  logic [10:0] main_cnt, next_main_cnt;
  logic [7:0] hold_cnt, next_hold_cnt;
  logic [2:0] err_cnt, next_err_cnt;
  logic [1:0] good_cnt, next_good_cnt;
  plsld_pump_type next_pump;
  logic next_reference_compare_freq, next_divided_vco_freq, next_drive_ok, next_locked;
  logic wake, clr;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    wake = enable & ~en_q;
    next_en_q = enable;
    next_ref_cnt = ref_cnt;
    next_main_cnt = main_cnt;
    next_reference_compare_freq = 1'b0;
    next_divided_vco_freq = 1'b0;
    next_pump = pump;
    next_hold_cnt = 8'h00;
    next_err_cnt = err_cnt;
    next_good_cnt = good_cnt;
    next_drive_ok = drive_ok;
    next_locked = locked;
    clr = 1'b0;
    if (!enable || wake) begin
      // Both dividers restart together so the first edges line up
      next_ref_cnt = 14'h0000;
      next_main_cnt = 11'h000;
      next_pump = '0;
      next_err_cnt = 3'h0;
      next_good_cnt = 2'h0;
      next_drive_ok = 1'b0;
      next_locked = 1'b0;
    end else begin
      if (osc_tick) begin
        if (ref_cnt >= cfg.ref_ratio - 14'h0001) begin
          next_ref_cnt = 14'h0000;
          next_reference_compare_freq = 1'b1;
        end else begin
          next_ref_cnt = ref_cnt + 14'h0001;
        end
      end
      if (vco_tick) begin
        if (main_cnt >= cfg.main_ratio - 11'h001) begin
          next_main_cnt = 11'h000;
          next_divided_vco_freq = 1'b1;
        end else begin
          next_main_cnt = main_cnt + 11'h001;
        end
      end
      if (reference_compare_freq) next_pump.up = 1'b1;
      if (divided_vco_freq) next_pump.dn = 1'b1;
      // Both sides stay on a little while, so zero error still pumps
      if (pump.up && pump.dn) begin
        if (hold_cnt >= 8'(DZ_PULSE_CYC - 1)) begin
          clr = 1'b1;
          next_pump = '0;
        end else begin
          next_hold_cnt = hold_cnt + 8'h01;
        end
      end
      if (osc_tick && (pump.up ^ pump.dn) && err_cnt != 3'h7) begin
        next_err_cnt = err_cnt + 3'h1;
      end
      if (err_cnt >= UNLOCK_OSC) begin
        next_locked = 1'b0;
        next_good_cnt = 2'h0;
      end
      if (clr) begin
        next_err_cnt = 3'h0;
        next_drive_ok = 1'b1; // First full comparison ends wake-up clamp
        if (err_cnt <= LOCK_OSC) begin
          if (good_cnt != LOCK_RUNS) next_good_cnt = good_cnt + 2'h1;
          if (good_cnt >= LOCK_RUNS - 2'h1) next_locked = 1'b1;
        end else begin
          next_good_cnt = 2'h0;
        end
      end
    end
  end

  always_comb modulus_ctrl = enable & (main_cnt < {4'h0, cfg.swallow});

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      ref_cnt <= 14'h0000;
      main_cnt <= 11'h000;
      hold_cnt <= 8'h00;
      err_cnt <= 3'h0;
      good_cnt <= 2'h0;
      pump <= '0;
      reference_compare_freq <= 1'b0;
      divided_vco_freq <= 1'b0;
      drive_ok <= 1'b0;
      locked <= 1'b0;
    end else begin
      en_q <= next_en_q;
      ref_cnt <= next_ref_cnt;
      main_cnt <= next_main_cnt;
      hold_cnt <= next_hold_cnt;
      err_cnt <= next_err_cnt;
      good_cnt <= next_good_cnt;
      pump <= next_pump;
      reference_compare_freq <= next_reference_compare_freq;
      divided_vco_freq <= next_divided_vco_freq;
      drive_ok <= next_drive_ok;
      locked <= next_locked;
    end
  end

endmodule

// >>> verilog/plsld_top.sv
// Top of the dual synthesizer control: pins, serial load, power save, lock output
`timescale 1ns/100ps
module plsld_top import plsld_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic if_power_save_n,
  input wire logic rf_power_save_n,
  input wire logic ref_osc_input,
  input wire logic if_divided_vco_freq,
  input wire logic rf_divided_vco_freq,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic load_strobe,
  output logic if_pd_out,
  output logic if_pd_oe,
  output logic rf_pd_out,
  output logic rf_pd_oe,
  output plsld_pump_type if_pump,
  output plsld_pump_type rf_pump,
  output logic if_modulus_ctrl,
  output logic rf_modulus_ctrl,
  output logic if_presc_sel,
  output logic rf_presc_sel,
  output logic lock_detect_out,
  output logic osc_buffer_on,
  output logic if_counters_on,
  output logic rf_counters_on
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [PIN_COUNT-1:0] pin_raw, pin_s1, pin_s2, pin_s3, pin_f, pin_d;
  logic [PIN_COUNT-1:0] next_pin_f, pin_rise;

  assign pin_raw = {rf_divided_vco_freq, if_divided_vco_freq, ref_osc_input, load_strobe,
                    serial_data, serial_clock, rf_power_save_n, if_power_save_n};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      // A level counts only once stages two and three agree, which rejects runt glitches
      always_comb next_pin_f[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_f[gi];
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_f <= '0;
      pin_d <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= next_pin_f;
      pin_d <= pin_f;
    end
  end

  assign pin_rise = pin_f & ~pin_d;

  // ----------------------------------------
  // Power control
  // ----------------------------------------
  logic if_on, rf_on, osc_tick;

  always_comb begin
    if_on = pin_f[PIN_PS_IF];
    rf_on = pin_f[PIN_PS_RF];
    // Oscillator buffer idles only with both sections asleep
    osc_tick = pin_rise[PIN_OSC] & (if_on | rf_on);
  end

  // ----------------------------------------
  // Serial shift and load
  // ----------------------------------------
  logic [WORD_BITS-1:0] shreg, next_shreg;
  plsld_cfg_type if_cfg, rf_cfg, next_if_cfg, next_rf_cfg;
  logic lds, next_lds;
  logic [1:0] test_sel, next_test_sel;

  function automatic logic [1:0] dest_of(input logic [WORD_BITS-1:0] w);
    dest_of = {w[POS_SEL_B], w[POS_SEL_A]};
  endfunction

  function automatic plsld_cfg_type load_main(input plsld_cfg_type c,
                                             input logic [WORD_BITS-1:0] w);
    load_main = c;
    load_main.presc_sel = w[POS_SW];
    load_main.phase_pol = w[POS_FC];
    load_main.swallow = w[POS_SWAL_LO +: 7];
    load_main.main_ratio = w[POS_MAIN_LO +: 11];
  endfunction

  always_comb begin
    next_shreg = shreg;
    next_if_cfg = if_cfg;
    next_rf_cfg = rf_cfg;
    next_lds = lds;
    next_test_sel = test_sel;
    // Shifting ignores power state, so words can be set up while asleep
    if (pin_rise[PIN_SCLK]) begin
      // Newest bit enters at the bottom; the word arrives top bit first
      next_shreg = {shreg[WORD_BITS-2:0], pin_f[PIN_SDATA]};
    end
    // Divider settings change only on the strobe, never mid-shift
    if (pin_rise[PIN_LOAD]) begin
      case (dest_of(shreg))
        DEST_IF_REF: begin
          next_if_cfg.ref_ratio = shreg[POS_REF_LO +: 14];
          next_test_sel = shreg[POS_TEST_LO +: 2];
        end
        DEST_RF_REF: begin
          next_rf_cfg.ref_ratio = shreg[POS_REF_LO +: 14];
          next_test_sel = shreg[POS_TEST_LO +: 2];
        end
        DEST_IF_MAIN: begin
          next_if_cfg = load_main(if_cfg, shreg);
          next_lds = shreg[POS_LDS];
        end
        DEST_RF_MAIN: begin
          next_rf_cfg = load_main(rf_cfg, shreg);
          next_lds = shreg[POS_LDS];
        end
        default: begin
          next_lds = lds;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shreg <= '0;
      if_cfg <= '{RESET_REF, RESET_MAIN, RESET_SWAL, 1'b0, 1'b0};
      rf_cfg <= '{RESET_REF, RESET_MAIN, RESET_SWAL, 1'b0, 1'b0};
      lds <= 1'b0;
      test_sel <= 2'h0;
    end else begin
      shreg <= next_shreg;
      if_cfg <= next_if_cfg;
      rf_cfg <= next_rf_cfg;
      lds <= next_lds;
      test_sel <= next_test_sel;
    end
  end

  // ----------------------------------------
  // Sections
  // ----------------------------------------
  logic if_ref_cmp, if_vco_cmp, if_ok, if_locked, rf_ref_cmp, rf_vco_cmp, rf_ok, rf_locked;

  plsld_section u_if (
    .clock(clock),
    .reset_n(reset_n),
    .enable(if_on),
    .osc_tick(osc_tick),
    .vco_tick(pin_rise[PIN_VCO_IF] & if_on),
    .cfg(if_cfg),
    .pump(if_pump),
    .reference_compare_freq(if_ref_cmp),
    .divided_vco_freq(if_vco_cmp),
    .modulus_ctrl(if_modulus_ctrl),
    .drive_ok(if_ok),
    .locked(if_locked)
  );

  plsld_section u_rf (
    .clock(clock),
    .reset_n(reset_n),
    .enable(rf_on),
    .osc_tick(osc_tick),
    .vco_tick(pin_rise[PIN_VCO_RF] & rf_on),
    .cfg(rf_cfg),
    .pump(rf_pump),
    .reference_compare_freq(rf_ref_cmp),
    .divided_vco_freq(rf_vco_cmp),
    .modulus_ctrl(rf_modulus_ctrl),
    .drive_ok(rf_ok),
    .locked(rf_locked)
  );

  // ----------------------------------------
  // Detector pins and lock output
  // ----------------------------------------
  logic next_if_pd_out, next_if_pd_oe, next_rf_pd_out, next_rf_pd_oe;
  logic next_lock, next_osc_on, test_sig;

  always_comb begin
    // Drive only with one side active; asleep or waking leaves the pin floating
    next_if_pd_oe = if_on & if_ok & (if_pump.up ^ if_pump.dn);
    next_if_pd_out = ~(if_pump.up ^ if_cfg.phase_pol);
    next_rf_pd_oe = rf_on & rf_ok & (rf_pump.up ^ rf_pump.dn);
    next_rf_pd_out = ~(rf_pump.up ^ rf_cfg.phase_pol);
    case (test_sel)
      2'h0: test_sig = if_ref_cmp;
      2'h1: test_sig = rf_ref_cmp;
      2'h2: test_sig = if_vco_cmp;
      2'h3: test_sig = rf_vco_cmp;
      default: test_sig = 1'b0;
    endcase
    // With lds clear a sleeping section reads as locked and any unlocked one pulls low; with lds set the pin carries test_sig
    next_lock = lds ? test_sig : ((if_locked | ~if_on) & (rf_locked | ~rf_on));
    next_osc_on = if_on | rf_on;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      if_pd_out <= 1'b0;
      if_pd_oe <= 1'b0;
      rf_pd_out <= 1'b0;
      rf_pd_oe <= 1'b0;
      lock_detect_out <= 1'b0;
      osc_buffer_on <= 1'b0;
      if_counters_on <= 1'b0;
      rf_counters_on <= 1'b0;
      if_presc_sel <= 1'b0;
      rf_presc_sel <= 1'b0;
    end else begin
      if_pd_out <= next_if_pd_out;
      if_pd_oe <= next_if_pd_oe;
      rf_pd_out <= next_rf_pd_out;
      rf_pd_oe <= next_rf_pd_oe;
      lock_detect_out <= next_lock;
      osc_buffer_on <= next_osc_on;
      if_counters_on <= if_on;
      rf_counters_on <= rf_on;
      if_presc_sel <= if_cfg.presc_sel;
      rf_presc_sel <= rf_cfg.presc_sel;
    end
  end

endmodule
